// file: common/jk_ff_pkg.sv
// Constants and types for the JK flip-flop with direct set
// Behaviour
// - Capture gated data inputs on trigger rise
// - Outputs change on later trigger fall, or on data edges in master-slave mode
// - Fall action: toggle, clear, set or hold
// - Direct set pair decode per level table
// - Direct set overrides trigger and data inputs
// - Set inputs active low; high has no effect
// - Master-slave variant: master follows data levels while trigger high
// - Master-slave: data edges may trigger change
// - Effective data is AND of three pins
// - Master-slave: both data falling with trigger high toggles
package jk_ff_pkg;

  // ************************************************************
  // Widths and reset values
  // ************************************************************
  localparam int SYNC_STAGES = 2;
  localparam int PIN_W = 10;
  localparam logic [9:0] PIN_RESET = 10'h006;
  localparam logic Q_RESET = 1'h0;
  localparam logic SET_INACTIVE = 1'h1;

  // ************************************************************
  // Direct set pair codes, preset then clear
  // ************************************************************
  localparam logic [1:0] SET_FORCE_LOW = 2'h2;
  localparam logic [1:0] SET_FORCE_HIGH = 2'h1;
  localparam logic [1:0] SET_BOTH_LOW = 2'h0;
  localparam logic [1:0] SET_NONE = 2'h3;

  // ************************************************************
  // Trigger phase states
  // ************************************************************
  typedef enum logic [1:0] {
    TRIG_LOW = 2'b00,
    TRIG_HIGH = 2'b01
  } trig_state_t;

  // ************************************************************
  // Pin bundle
  // ************************************************************
  typedef struct packed {
    logic trigger;
    logic set_a;
    logic set_b;
    logic set_c;
    logic clr_a;
    logic clr_b;
    logic clr_c;
    logic preset_n;
    logic clear_n;
    logic ms_mode;
  } pins_t;

endpackage : jk_ff_pkg

// file: core/pin_sync.sv
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1_reg;

  // ************************************************************
  // Synchroniser stages
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stage1_reg <= RESET_VALUE;
      sync_o <= RESET_VALUE;
    end
    else
    begin
      stage1_reg <= async_i;
      sync_o <= stage1_reg;
    end
  end

endmodule : pin_sync

// file: core/jk_flip_flop_with_direct_set.sv
// JK flip-flop with gated data inputs and direct set override
`timescale 1ns/1ps

module jk_flip_flop_with_direct_set (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic trigger_i,
  input wire logic set_side_gate_in_a_i,
  input wire logic set_side_gate_in_b_i,
  input wire logic set_side_gate_in_c_i,
  input wire logic clear_side_gate_in_a_i,
  input wire logic clear_side_gate_in_b_i,
  input wire logic clear_side_gate_in_c_i,
  input wire logic async_preset_n_i,
  input wire logic async_clear_n_i,
  input wire logic master_slave_mode_i,
  output logic true_out_o,
  output logic comp_out_o
);

  // ************************************************************
  // Declarations
  // ************************************************************
  jk_ff_pkg::pins_t raw_pins;
  jk_ff_pkg::pins_t pins;
  jk_ff_pkg::trig_state_t trig_state_reg;
  jk_ff_pkg::trig_state_t trig_state_next;
  logic j_eff;
  logic k_eff;
  logic j_prev_reg;
  logic k_prev_reg;
  logic master_j_reg;
  logic master_k_reg;
  logic trig_rise;
  logic trig_fall;
  logic j_fall;
  logic k_fall;
  logic data_trigger;
  logic [1:0] set_pair;
  logic q_reg;
  logic q_next;
  logic true_next;
  logic comp_next;

  // ************************************************************
  // Pin synchronisation
  // ************************************************************
  always_comb
  begin
    raw_pins.trigger = trigger_i;
    raw_pins.set_a = set_side_gate_in_a_i;
    raw_pins.set_b = set_side_gate_in_b_i;
    raw_pins.set_c = set_side_gate_in_c_i;
    raw_pins.clr_a = clear_side_gate_in_a_i;
    raw_pins.clr_b = clear_side_gate_in_b_i;
    raw_pins.clr_c = clear_side_gate_in_c_i;
    raw_pins.preset_n = async_preset_n_i;
    raw_pins.clear_n = async_clear_n_i;
    raw_pins.ms_mode = master_slave_mode_i;
  end

  pin_sync #(
    .WIDTH(jk_ff_pkg::PIN_W),
    .RESET_VALUE(jk_ff_pkg::PIN_RESET)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(raw_pins),
    .sync_o(pins)
  );

  // ************************************************************
  // Gated data inputs
  // ************************************************************
  assign j_eff = pins.set_a & pins.set_b & pins.set_c;
  assign k_eff = pins.clr_a & pins.clr_b & pins.clr_c;

  // ************************************************************
  // Trigger phase tracking
  // ************************************************************
  always_comb
  begin
    trig_state_next = trig_state_reg;
    trig_rise = 1'b0;
    trig_fall = 1'b0;
    case (trig_state_reg)
      jk_ff_pkg::TRIG_LOW:
      begin
        if (pins.trigger)
        begin
          trig_state_next = jk_ff_pkg::TRIG_HIGH;
          trig_rise = 1'b1;
        end
      end
      jk_ff_pkg::TRIG_HIGH:
      begin
        if (!pins.trigger)
        begin
          trig_state_next = jk_ff_pkg::TRIG_LOW;
          trig_fall = 1'b1;
        end
      end
      default:
      begin
        trig_state_next = jk_ff_pkg::TRIG_LOW;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trig_state_reg <= jk_ff_pkg::TRIG_LOW;
    end
    else
    begin
      trig_state_reg <= trig_state_next;
    end
  end

  // ************************************************************
  // Data edge detection
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      j_prev_reg <= 1'b0;
      k_prev_reg <= 1'b0;
    end
    else
    begin
      j_prev_reg <= j_eff;
      k_prev_reg <= k_eff;
    end
  end

  assign j_fall = j_prev_reg & ~j_eff;
  assign k_fall = k_prev_reg & ~k_eff;
  // Data edges act only in master-slave mode, trigger held high
  assign data_trigger = pins.ms_mode & pins.trigger & ~trig_rise
    & (j_fall | k_fall);

  // ************************************************************
  // Master stage
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      master_j_reg <= 1'b0;
      master_k_reg <= 1'b0;
    end
    else if (trig_rise)
    begin
      master_j_reg <= j_eff;
      master_k_reg <= k_eff;
    end
    else if (pins.ms_mode && pins.trigger)
    begin
      // Level response: master follows data while trigger high
      master_j_reg <= j_eff;
      master_k_reg <= k_eff;
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  assign set_pair = {pins.preset_n, pins.clear_n};

  always_comb
  begin
    q_next = q_reg;
    true_next = q_reg;
    comp_next = ~q_reg;
    case (set_pair)
      jk_ff_pkg::SET_FORCE_LOW:
      begin
        q_next = 1'b0;
      end
      jk_ff_pkg::SET_FORCE_HIGH:
      begin
        q_next = 1'b1;
      end
      jk_ff_pkg::SET_BOTH_LOW:
      begin
        q_next = q_reg;
      end
      jk_ff_pkg::SET_NONE:
      begin
        // Clocked path only while both set inputs high
        if (data_trigger)
        begin
          if (j_fall && k_fall)
          begin
            q_next = ~q_reg;
          end
          else if (j_fall)
          begin
            q_next = 1'b1;
          end
          else
          begin
            q_next = 1'b0;
          end
        end
        else if (trig_fall)
        begin
          case ({master_j_reg, master_k_reg})
            2'b11: q_next = ~q_reg;
            2'b01: q_next = 1'b0;
            2'b10: q_next = 1'b1;
            default: q_next = q_reg;
          endcase
        end
      end
      default:
      begin
        q_next = q_reg;
      end
    endcase
    true_next = q_next;
    comp_next = ~q_next;
    if (set_pair == jk_ff_pkg::SET_BOTH_LOW)
    begin
      true_next = 1'b1;
      comp_next = 1'b1;
    end
  end

  // ************************************************************
  // Stored state
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q_reg <= jk_ff_pkg::Q_RESET;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  // ************************************************************
  // Output flops
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      true_out_o <= jk_ff_pkg::Q_RESET;
      comp_out_o <= ~jk_ff_pkg::Q_RESET;
    end
    else
    begin
      true_out_o <= true_next;
      comp_out_o <= comp_next;
    end
  end

endmodule : jk_flip_flop_with_direct_set

// file: tb/jk_gate_drive.sv
// Model of the gate logic that drives the flip-flop pins
`timescale 1ns/1ps

module jk_gate_drive (
  input wire jk_ff_pkg::pins_t cmd_i,
  output jk_ff_pkg::pins_t pins_o
);
  // ********
  // Pin drive
  // ********
  // Pins pass through from the command unchanged, set lines included
  assign pins_o = cmd_i;
endmodule : jk_gate_drive

// file: tb/jk_ff_assertions.sv
// Checker of the flip-flop port behaviour
`timescale 1ns/1ps

module jk_ff_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic trigger_i,
  input wire logic set_side_gate_in_a_i,
  input wire logic set_side_gate_in_b_i,
  input wire logic set_side_gate_in_c_i,
  input wire logic clear_side_gate_in_a_i,
  input wire logic clear_side_gate_in_b_i,
  input wire logic clear_side_gate_in_c_i,
  input wire logic async_preset_n_i,
  input wire logic async_clear_n_i,
  input wire logic master_slave_mode_i,
  input wire logic true_out_o,
  input wire logic comp_out_o
);
  // ********
  // Pin history
  // ********
  logic [4:0] th, jh, kh, ch, mh;
  logic [4:0][1:0] sh;
  logic [2:0] cnt;
  logic [1:0] cap;
  wire logic ok = cnt == 3'h5;
  wire logic [1:0] s = {async_preset_n_i, async_clear_n_i};
  wire logic [1:0] q = {true_out_o, comp_out_o};
  wire logic j = set_side_gate_in_a_i & set_side_gate_in_b_i
    & set_side_gate_in_c_i;
  wire logic k = clear_side_gate_in_a_i & clear_side_gate_in_b_i
    & clear_side_gate_in_c_i;
  always_ff @(posedge clk_i)
  begin
    th <= {th[3:0], trigger_i};
    jh <= {jh[3:0], j};
    kh <= {kh[3:0], k};
    sh <= {sh[3:0], s};
    ch <= {ch[3:0], s == 2'h3 && !master_slave_mode_i};
    mh <= {mh[3:0], s == 2'h3 && master_slave_mode_i && trigger_i};
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt <= 3'h0;
    else if (!ok)
      cnt <= cnt + 3'h1;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cap <= 2'h0;
    else if (th[2] && !th[3])
      cap <= {jh[2], kh[2]};
  end
  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_FORCE_LOW:
    assert property (ok && sh[2] == 2'h2 |-> q == 2'h1) else $error("lo");
  AST_FORCE_HIGH:
    assert property (ok && sh[2] == 2'h1 |-> q == 2'h2) else $error("hi");
  AST_BOTH_LOW:
    assert property (ok && sh[2] == 2'h0 |-> q == 2'h3) else $error("both");
  AST_COMPL:
    assert property (ok && sh[2] == 2'h3 |-> ^q) else $error("compl");
  AST_RESET:
    assert property ($past(rst_i) |-> q == 2'h1) else $error("reset");
  AST_STABLE:
    assert property (ok && ch[2] && ch[3] && !(th[3] && !th[2])
      |-> $stable(q)) else $error("stray change");
  AST_CLOCKED:
    assert property (ok && ch[2] && ch[3] && th[3] && !th[2]
      |-> true_out_o == (cap == 2'h3 ? !$past(true_out_o) :
      cap == 2'h0 ? $past(true_out_o) : cap[1])) else $error("clocked");
  AST_MS_TOGGLE:
    assert property (ok && mh[2] && mh[3] && mh[4] && jh[3] && kh[3]
      && !jh[2] && !kh[2] |-> true_out_o != $past(true_out_o))
      else $error("ms toggle");
endmodule : jk_ff_checker

bind jk_flip_flop_with_direct_set jk_ff_checker u_chk (.clk_i, .rst_i,
  .trigger_i, .set_side_gate_in_a_i, .set_side_gate_in_b_i,
  .set_side_gate_in_c_i, .clear_side_gate_in_a_i, .clear_side_gate_in_b_i,
  .clear_side_gate_in_c_i, .async_preset_n_i, .async_clear_n_i,
  .master_slave_mode_i, .true_out_o, .comp_out_o);

// file: tb/jk_flip_flop_with_direct_set_tb_top.sv
// Self-checking bench of the flip-flop with direct set
`timescale 1ns/1ps

module jk_flip_flop_with_direct_set_tb_top;
  // ********
  // Clock, pins and scoreboard
  // ********
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic look = 1'h0;
  logic q = 1'h0;
  logic true_out_o, comp_out_o;
  logic [31:0] rnd = 32'h2816;
  logic [1:0] exp_q[$];
  logic [1:0] codes[5] = '{2'h2, 2'h0, 2'h3, 2'h1, 2'h3};
  int err_count = 0;
  int compares = 0;
  jk_ff_pkg::pins_t p = 10'h006;
  jk_ff_pkg::pins_t cmd = 10'h006;
  jk_ff_pkg::pins_t pins;
  initial forever #50 clk_i = !clk_i;
  jk_gate_drive u_drv (.cmd_i(cmd), .pins_o(pins));
  jk_flip_flop_with_direct_set u_dut (.clk_i, .rst_i,
    .trigger_i(pins.trigger), .set_side_gate_in_a_i(pins.set_a),
    .set_side_gate_in_b_i(pins.set_b), .set_side_gate_in_c_i(pins.set_c),
    .clear_side_gate_in_a_i(pins.clr_a), .clear_side_gate_in_b_i(pins.clr_b),
    .clear_side_gate_in_c_i(pins.clr_c), .async_preset_n_i(pins.preset_n),
    .async_clear_n_i(pins.clear_n), .master_slave_mode_i(pins.ms_mode),
    .true_out_o, .comp_out_o);
  function automatic logic [31:0] nxt(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : nxt
  function automatic logic [2:0] gate(input logic v, input logic [2:0] r);
    return v ? 3'h7 : r ^ {2'h0, &r};
  endfunction : gate
  task automatic check(input logic [1:0] seen, input logic [1:0] want);
    compares++;
    if (seen !== want)
    begin
      err_count++;
      $display("unexpected at %0t: %h vs %h", $time, seen, want);
    end
  endtask : check
  task automatic stop_test();
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic jk(input logic jv, input logic kv);
    rnd = nxt(rnd);
    {p.set_a, p.set_b, p.set_c} = gate(jv, rnd[2:0]);
    {p.clr_a, p.clr_b, p.clr_c} = gate(kv, rnd[5:3]);
  endtask : jk
  task automatic go(input logic both = 1'h0);
    @(posedge clk_i);
    cmd <= p;
    repeat (4) @(posedge clk_i);
    exp_q.push_back(both ? 2'h3 : {q, !q});
    look <= 1'h1;
    @(posedge clk_i);
    look <= 1'h0;
  endtask : go
  always @(negedge clk_i)
    if (look)
      check({true_out_o, comp_out_o}, exp_q.pop_front());
  initial
  begin
    repeat (3000) @(posedge clk_i);
    err_count++;
    stop_test();
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    go();
    for (int i = 0; i < 8; i++)
    begin
      jk(i[1], i[0]);
      go();
      p.trigger = 1'h1;
      go();
      jk(!i[1], i[0]);
      go();
      p.trigger = 1'h0;
      if (i[1] | i[0])
        q = i[1] & i[0] ? !q : i[1];
      go();
    end
    jk(1'h0, 1'h0);
    foreach (codes[n])
    begin
      {p.preset_n, p.clear_n} = codes[n];
      if (^codes[n])
        q = codes[n][0];
      go(codes[n] == 2'h0);
      p.trigger = 1'h1;
      go(codes[n] == 2'h0);
      p.trigger = 1'h0;
      go(codes[n] == 2'h0);
    end
    p.ms_mode = 1'h1;
    jk(1'h1, 1'h1);
    go();
    p.trigger = 1'h1;
    go();
    jk(1'h0, 1'h0);
    q = !q;
    go();
    jk(1'h1, 1'h1);
    go();
    jk(1'h0, 1'h1);
    q = 1'h1;
    go();
    jk(1'h1, 1'h1);
    go();
    jk(1'h1, 1'h0);
    q = 1'h0;
    go();
    stop_test();
  end
endmodule : jk_flip_flop_with_direct_set_tb_top
